// ==== common/uhb_defs.vh ====
/*
 Constants for the parallel host port block: AXI4-Lite register offsets,
 field positions, reset values and timing counts.
 Assumes a 10 MHz reference clock.
*/
// Overview of operation
// - Bus select high picks strobe-style bus, low picks read/write-line bus.
// - Strobe mode: write strobe fall starts write, rise latches data to addressed register.
// - Read/write-line mode: direction high means read, low means write.
// - Bus transactions are answered only while device select is low; the code checks select for strobe-mode reads only at the read strobe fall.
// - Strobe mode: interrupt active high, driven when control bit 3 set, else floating.
// - Read/write-line mode: interrupt active low, open drain, pulled up outside.
// - Control bit 6 clear: normal format, transmit idles high, also during reset.
// - Control bit 6 set: infrared coding on transmit and receive, idle level low; the code codes transmit only, rx is just status bit 2.
// - Clear-to-send gates transmission under feature bit 7, reported in status bit 4.
// - Data-set-ready, carrier-detect and ring inputs are status only.
// - Power-save input high isolates the data bus and ignores bus activity.
// - Strobe mode: read strobe fall drives addressed byte until strobe rises.
// - Reset pin polarity follows bus mode; minimum pulse resets registers and outputs.
`ifndef UHB_DEFS_VH
`define UHB_DEFS_VH

`define UHB_OFS_MODEM_CTRL 6'h00
`define UHB_OFS_EXT_FEAT 6'h04
`define UHB_OFS_MODEM_STAT 6'h08
`define UHB_OFS_INT_STAT 6'h0C
`define UHB_OFS_INT_MASK 6'h10
`define UHB_OFS_HOST_LAST 6'h14

`define UHB_MCR_DTR 0
`define UHB_MCR_RTS 1
`define UHB_MCR_INTEN 3
`define UHB_MCR_IRDA 6
`define UHB_EFR_AUTORTS 6
`define UHB_EFR_AUTOCTS 7
`define UHB_MSR_MODE 0
`define UHB_MSR_ISO 1
`define UHB_MSR_RXLVL 2
`define UHB_MSR_CTS 4
`define UHB_MSR_DSR 5
`define UHB_MSR_RI 6
`define UHB_MSR_CD 7

`define UHB_EV_HWRITE 0
`define UHB_EV_HREAD 1
`define UHB_EV_CTS 2
`define UHB_EV_TXDONE 3
`define UHB_EV_W 4

`define UHB_MCR_RST 8'h00
`define UHB_EFR_RST 8'h00
`define UHB_MASK_RST 4'h0
// Idle level of every synchronised pin, so no false edge follows reset
`define UHB_PIN_IDLE 22'h3C003E

`define UHB_CLK_NS 100
`define UHB_RST_MIN_NS 40
`define UHB_RST_MIN_CYC ((`UHB_RST_MIN_NS + `UHB_CLK_NS - 1) / `UHB_CLK_NS)
`define UHB_BAUD_DIV 4'h1
`define UHB_SUB_LAST 4'hF
`define UHB_IR_PULSE 4'h3
`define UHB_TX_ADDR 3'h0
`define UHB_MSR_ADDR 3'h6

`endif

// ==== rtl/uhb_sync.v ====
/*
 Two-flop synchroniser for a vector of asynchronous pin levels.
 Assumes each bit is an independent level; no bus coherence is promised.
*/
`timescale 1ns/1ps
module uhb_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire ref_clk_i,
	input wire nrst_i,
	// Levels
	input wire [WIDTH-1:0] async_i,
	output reg [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_reg <= RST_VAL;
			sync_o <= RST_VAL;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule

// ==== rtl/uhb_host_port.v ====
/*
 Parallel host port of a serial controller: strobe-style or read/write-line
 host bus, interrupt pin, serial transmit pin, modem pins, power isolation,
 and an AXI4-Lite slave for the control and status registers.
 Assumes all pin inputs are asynchronous to ref_clk_i; host strobes must be
 held well over two clock periods so the synchronised edges are seen.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "uhb_defs.vh"
module uhb_host_port (
	// Clock and reset
	input wire ref_clk_i,
	input wire nrst_i,
	// Host bus pins
	input wire bus_sel_i,
	input wire cs_n_i,
	input wire write_strobe_n_i,
	input wire read_strobe_n_i,
	input wire [2:0] addr_i,
	input wire [7:0] data_i,
	output reg [7:0] data_o,
	output reg data_oe_o,
	input wire reset_pin_i,
	input wire power_isolate_in_i,
	// Interrupt pin
	output reg int_o,
	output reg int_oe_o,
	// Serial and modem pins
	output reg tx_o,
	input wire rx_i,
	output reg rts_n_o,
	output reg dtr_n_o,
	input wire cts_n_i,
	input wire dsr_n_i,
	input wire cd_n_i,
	input wire ri_n_i,
	// AXI4-Lite slave
	input wire [5:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [5:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Interrupt to system
	output reg irq_o
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_START = 4'b0010;
	localparam ST_DATA = 4'b0100;
	localparam ST_STOP = 4'b1000;

	wire [21:0] pin_s;
	wire mode_s, cs_n_s, wr_n_s, rd_n_s, rst_pin_s, rx_s, cts_n_s, dsr_n_s, cd_n_s, ri_n_s, iso_s;
	wire [2:0] addr_s;
	wire [7:0] data_s;

	uhb_sync #(.WIDTH(22), .RST_VAL(`UHB_PIN_IDLE)) u_sync (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.async_i({bus_sel_i, cs_n_i, write_strobe_n_i, read_strobe_n_i, addr_i, data_i,
			reset_pin_i, rx_i, cts_n_i, dsr_n_i, cd_n_i, ri_n_i, power_isolate_in_i}),
		.sync_o(pin_s)
	);
	assign {mode_s, cs_n_s, wr_n_s, rd_n_s, addr_s, data_s, rst_pin_s, rx_s, cts_n_s,
		dsr_n_s, cd_n_s, ri_n_s, iso_s} = pin_s;

	reg wr_n_reg, rd_n_reg, cs_n_reg, cts_n_reg;
	reg [7:0] modem_control_reg, extended_feature_reg;
	reg [`UHB_EV_W-1:0] int_stat_reg, int_mask_reg;
	reg [7:0] host_file [0:7];
	reg [7:0] host_last_reg;
	reg [2:0] acc_addr_reg;
	reg acc_read_reg, acc_busy_reg;
	reg soft_rst_reg;
	reg [3:0] tx_state_reg, sub_reg, div_reg;
	reg [2:0] bit_reg;
	reg [7:0] tx_shift_reg;
	reg tx_pend_reg;
	reg [7:0] tx_hold_reg;
	reg aw_got_reg, w_got_reg;
	reg [5:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;

	// Reset pin polarity follows bus mode
	wire pin_rst_act = mode_s ? rst_pin_s : ~rst_pin_s;
	wire live = ~iso_s & ~soft_rst_reg;
	wire strobe_mode = mode_s;
	wire wr_fall = wr_n_reg & ~wr_n_s;
	wire wr_rise = ~wr_n_reg & wr_n_s;
	wire rd_fall = rd_n_reg & ~rd_n_s;
	wire rd_rise = ~rd_n_reg & rd_n_s;
	wire cs_fall = cs_n_reg & ~cs_n_s;
	wire cs_rise = ~cs_n_reg & cs_n_s;
	wire [7:0] msr_val = {~cd_n_s, ~ri_n_s, ~dsr_n_s, ~cts_n_s, 1'b0, rx_s, iso_s, mode_s};

	// Host write commit and read event, per bus mode
	wire host_wr = live & (strobe_mode ? (wr_rise & ~cs_n_s & acc_busy_reg)
		: (cs_rise & acc_busy_reg & ~acc_read_reg));
	wire host_rd = live & (strobe_mode ? (rd_rise & acc_busy_reg & acc_read_reg)
		: (cs_rise & acc_busy_reg & acc_read_reg));
	wire [2:0] wr_addr = strobe_mode ? addr_s : acc_addr_reg;
	wire [7:0] rd_byte = (acc_addr_reg == `UHB_MSR_ADDR) ? msr_val : host_file[acc_addr_reg];

	wire tx_done = tx_state_reg[3] & (sub_reg == `UHB_SUB_LAST) & (div_reg == `UHB_BAUD_DIV);
	wire [`UHB_EV_W-1:0] ev = {tx_done, cts_n_s ^ cts_n_reg, host_rd, host_wr};

	// AXI write path
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_go = aw_got_reg & w_got_reg & ~s_axi_bvalid;
	wire wr_map = (aw_addr_reg == `UHB_OFS_MODEM_CTRL) | (aw_addr_reg == `UHB_OFS_EXT_FEAT)
		| (aw_addr_reg == `UHB_OFS_INT_STAT) | (aw_addr_reg == `UHB_OFS_INT_MASK);
	wire [`UHB_EV_W-1:0] w1c = (wr_go & w_strb_reg[0] & (aw_addr_reg == `UHB_OFS_INT_STAT))
		? w_data_reg[`UHB_EV_W-1:0] : {`UHB_EV_W{1'b0}};

	// Pin reset filter and edge history
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			soft_rst_reg <= 1'b0;
			wr_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			cs_n_reg <= 1'b1;
			cts_n_reg <= 1'b1;
		end else begin
			// One cycle already covers the minimum pulse width
			soft_rst_reg <= pin_rst_act;
			wr_n_reg <= wr_n_s;
			rd_n_reg <= rd_n_s;
			cs_n_reg <= cs_n_s;
			cts_n_reg <= cts_n_s;
		end
	end

	// Host bus access sequencing
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			acc_busy_reg <= 1'b0;
			acc_read_reg <= 1'b0;
			acc_addr_reg <= 3'h0;
			data_o <= 8'h00;
			data_oe_o <= 1'b0;
			host_last_reg <= 8'h00;
		end else if (!live) begin
			acc_busy_reg <= 1'b0;
			data_oe_o <= 1'b0;
			if (soft_rst_reg) begin
				host_last_reg <= 8'h00;
			end
		end else if (strobe_mode) begin
			if (wr_fall && !cs_n_s) begin
				acc_busy_reg <= 1'b1;
				acc_read_reg <= 1'b0;
			end else if (rd_fall && !cs_n_s) begin
				acc_busy_reg <= 1'b1;
				acc_read_reg <= 1'b1;
				acc_addr_reg <= addr_s;
			end else if (wr_rise || rd_rise) begin
				acc_busy_reg <= 1'b0;
			end
			data_oe_o <= acc_busy_reg & acc_read_reg & ~rd_n_s & ~rd_rise;
			data_o <= rd_byte;
			if (host_wr) begin
				host_last_reg <= data_s;
			end
		end else begin
			if (cs_fall) begin
				acc_busy_reg <= 1'b1;
			end else if (cs_rise) begin
				acc_busy_reg <= 1'b0;
			end
			if (!cs_n_s) begin
				acc_read_reg <= wr_n_s;
				acc_addr_reg <= addr_s;
			end
			data_oe_o <= acc_busy_reg & ~cs_n_s & wr_n_s;
			data_o <= rd_byte;
			if (host_wr) begin
				host_last_reg <= data_s;
			end
		end
	end

	// Host register file, no reset on the storage itself
	always @(posedge ref_clk_i) begin
		if (host_wr) begin
			host_file[wr_addr] <= data_s;
		end
	end

	// Transmit holding byte from host writes to address zero
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_pend_reg <= 1'b0;
			tx_hold_reg <= 8'h00;
		end else if (soft_rst_reg) begin
			tx_pend_reg <= 1'b0;
		end else if (host_wr && wr_addr == `UHB_TX_ADDR) begin
			tx_pend_reg <= 1'b1;
			tx_hold_reg <= data_s;
		end else if (tx_state_reg[0] && tx_pend_reg
			&& !(extended_feature_reg[`UHB_EFR_AUTOCTS] && cts_n_s)) begin
			tx_pend_reg <= 1'b0;
		end
	end

	// Serial transmitter: sixteen sub-ticks per bit
	wire sub_tick = (div_reg == `UHB_BAUD_DIV);
	wire bit_end = sub_tick & (sub_reg == `UHB_SUB_LAST);
	wire cur_bit = tx_state_reg[1] ? 1'b0 : tx_state_reg[2] ? tx_shift_reg[0] : 1'b1;
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_state_reg <= ST_IDLE;
			sub_reg <= 4'h0;
			div_reg <= 4'h1;
			bit_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_o <= 1'b1;
		end else if (soft_rst_reg) begin
			tx_state_reg <= ST_IDLE;
			sub_reg <= 4'h0;
			div_reg <= 4'h1;
			tx_o <= 1'b1;
		end else begin
			div_reg <= sub_tick ? 4'h1 : div_reg + 4'h1;
			if (sub_tick) begin
				sub_reg <= sub_reg + 4'h1;
			end
			case (tx_state_reg)
				ST_IDLE: begin
					sub_reg <= 4'h0;
					if (tx_pend_reg && !(extended_feature_reg[`UHB_EFR_AUTOCTS] && cts_n_s)) begin
						tx_state_reg <= ST_START;
						tx_shift_reg <= tx_hold_reg;
					end
				end
				ST_START: begin
					if (bit_end) begin
						tx_state_reg <= ST_DATA;
						bit_reg <= 3'h0;
					end
				end
				ST_DATA: begin
					if (bit_end) begin
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == 3'h7) begin
							tx_state_reg <= ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (bit_end) begin
						tx_state_reg <= ST_IDLE;
					end
				end
				default: tx_state_reg <= ST_IDLE;
			endcase
			// Infrared: short high pulse for each zero bit, low otherwise
			if (modem_control_reg[`UHB_MCR_IRDA]) begin
				tx_o <= ~cur_bit & (sub_reg < `UHB_IR_PULSE);
			end else begin
				tx_o <= cur_bit;
			end
		end
	end

	// Modem outputs and interrupt pin
	wire int_act = |(int_stat_reg & int_mask_reg);
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rts_n_o <= 1'b1;
			dtr_n_o <= 1'b1;
			int_o <= 1'b0;
			int_oe_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			// Automatic mode relies on software raising the control bit first
			rts_n_o <= ~modem_control_reg[`UHB_MCR_RTS];
			dtr_n_o <= ~modem_control_reg[`UHB_MCR_DTR];
			irq_o <= int_act;
			if (mode_s) begin
				int_o <= int_act;
				int_oe_o <= modem_control_reg[`UHB_MCR_INTEN];
			end else begin
				int_o <= 1'b0;
				int_oe_o <= int_act;
			end
		end
	end

	// AXI4-Lite slave and control registers
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h00000000;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 6'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			modem_control_reg <= `UHB_MCR_RST;
			extended_feature_reg <= `UHB_EFR_RST;
			int_mask_reg <= `UHB_MASK_RST;
			int_stat_reg <= {`UHB_EV_W{1'b0}};
		end else begin
			s_axi_awready <= ~aw_got_reg & ~aw_take & ~s_axi_bvalid;
			s_axi_wready <= ~w_got_reg & ~w_take & ~s_axi_bvalid;
			if (aw_take) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			// Events win over a simultaneous clear
			int_stat_reg <= (int_stat_reg & ~w1c) | ev;
			if (wr_go) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
				if (w_strb_reg[0]) begin
					case (aw_addr_reg)
						`UHB_OFS_MODEM_CTRL: modem_control_reg <= w_data_reg[7:0];
						`UHB_OFS_EXT_FEAT: extended_feature_reg <= w_data_reg[7:0];
						`UHB_OFS_INT_MASK: int_mask_reg <= w_data_reg[`UHB_EV_W-1:0];
						default: ;
					endcase
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (soft_rst_reg) begin
				modem_control_reg <= `UHB_MCR_RST;
				extended_feature_reg <= `UHB_EFR_RST;
				int_mask_reg <= `UHB_MASK_RST;
				int_stat_reg <= {`UHB_EV_W{1'b0}};
			end
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					`UHB_OFS_MODEM_CTRL: s_axi_rdata <= {24'h000000, modem_control_reg};
					`UHB_OFS_EXT_FEAT: s_axi_rdata <= {24'h000000, extended_feature_reg};
					`UHB_OFS_MODEM_STAT: s_axi_rdata <= {24'h000000, msr_val};
					`UHB_OFS_INT_STAT: s_axi_rdata <= {28'h0000000, int_stat_reg};
					`UHB_OFS_INT_MASK: s_axi_rdata <= {28'h0000000, int_mask_reg};
					`UHB_OFS_HOST_LAST: s_axi_rdata <= {24'h000000, host_last_reg};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ==== bench/uhb_host_model.sv ====
/*
 Host processor model for the parallel bus: strobe-style and read/write-line cycles.
 Assumes the bus mode pin has settled before acc is called.
*/
`timescale 1ns/1ps
module uhb_host_model (
	// Clock and bus mode
	input wire clk_i,
	input wire bus_sel_i,
	// Host bus pins
	output logic cs_n_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic [2:0] addr_o,
	output logic [7:0] data_o,
	input wire [7:0] data_i,
	input wire data_oe_i
);
	initial begin
		{cs_n_o, wr_n_o, rd_n_o, addr_o, data_o} = 14'h3800;
	end

	task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		addr_o <= a;
		// Released bus shows the inverse, never a stale copy
		data_o <= wr ? d : ~data_o;
		if (!bus_sel_i)
			wr_n_o <= !wr;
		repeat (2) @(posedge clk_i);
		if (bus_sel_i)
			{wr_n_o, rd_n_o} <= {!wr, wr};
		repeat (7) @(posedge clk_i);
		q = data_oe_i ? data_i : 8'hXX;
		if (bus_sel_i)
			{wr_n_o, rd_n_o} <= 2'h3;
		repeat (5) @(posedge clk_i);
		{cs_n_o, wr_n_o, rd_n_o} <= 3'h7;
		// Data held past select release: line writes latch it there
		repeat (4) @(posedge clk_i);
		data_o <= ~data_o;
	endtask
endmodule

// ==== bench/uhb_host_port_checker.sv ====
/*
 Pin assertions for the parallel host port.
 Assumes asynchronous pins: each check allows two sync flops and one register.
*/
`timescale 1ns/1ps
module uhb_host_port_checker (
	// Clock and reset
	input wire ref_clk_i,
	input wire nrst_i,
	// Watched pins
	input wire bus_sel_i,
	input wire cs_n_i,
	input wire write_strobe_n_i,
	input wire read_strobe_n_i,
	input wire reset_pin_i,
	input wire power_isolate_in_i,
	input wire data_oe_o,
	input wire int_o,
	input wire int_oe_o,
	input wire tx_o,
	input wire irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	a_tx_rst_idle: assert property ($rose(nrst_i) |-> tx_o)
		else $error("tx not idle after reset");
	a_pin_rst_tx: assert property ((bus_sel_i && reset_pin_i)[*5] |-> tx_o)
		else $error("tx not idle under pin reset");
	a_iso_no_drive: assert property (power_isolate_in_i[*5] |-> !data_oe_o)
		else $error("data driven while isolated");
	a_desel_no_drive: assert property (cs_n_i[*6] |-> !data_oe_o)
		else $error("data driven while deselected");
	a_strobe_idle_off: assert property ((bus_sel_i && read_strobe_n_i)[*6] |-> !data_oe_o)
		else $error("data driven without read strobe");
	a_strobe_read_on: assert property (
		(bus_sel_i && !cs_n_i && !read_strobe_n_i && !power_isolate_in_i)[*6] |-> data_oe_o)
		else $error("strobe read not driven");
	a_rwl_write_off: assert property ((!bus_sel_i && !write_strobe_n_i)[*6] |-> !data_oe_o)
		else $error("data driven during write");
	a_rwl_read_on: assert property (
		(!bus_sel_i && !cs_n_i && write_strobe_n_i && !power_isolate_in_i)[*6] |-> data_oe_o)
		else $error("line read not driven");
	a_strobe_int_lvl: assert property (bus_sel_i[*5] ##0 int_o |-> irq_o || $past(irq_o))
		else $error("interrupt pin high without cause");
	a_rwl_int_low: assert property (!bus_sel_i[*5] |-> !int_o)
		else $error("open drain pin drives high");
	a_rwl_int_drive: assert property (!bus_sel_i[*5] ##0 int_oe_o |-> irq_o || $past(irq_o))
		else $error("open drain pulled low without cause");
endmodule

bind uhb_host_port uhb_host_port_checker chk (.ref_clk_i, .nrst_i, .bus_sel_i, .cs_n_i,
	.write_strobe_n_i, .read_strobe_n_i, .reset_pin_i, .power_isolate_in_i, .data_oe_o,
	.int_o, .int_oe_o, .tx_o, .irq_o);

// ==== bench/tb.sv ====
/*
 Testbench for the parallel host port: AXI4-Lite tasks, host cycles, frame checks.
 Assumes the hand-over latencies; modem pins packed {ri, cd, dsr, cts}, active low.
*/
`timescale 1ns/1ps
`include "uhb_defs.vh"
module tb;
	logic clk = 1'b0, nrst = 1'b0, bsel = 1'b1, rpin = 1'b0, iso = 1'b0, rx = 1'b1;
	logic [3:0] mdm_n = 4'h6;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire cs_n, wsn, rsn, oe, int_o, int_oe, tx, rts_n, dtr_n, awrdy, wrdy, bvalid, arrdy;
	wire rvalid, irq;
	wire [2:0] ha;
	wire [7:0] hd, dq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	logic [7:0] q;
	int failures = 0, num_checks = 0, h = 0;

	always #50 clk = ~clk;

	uhb_host_model host (.clk_i(clk), .bus_sel_i(bsel), .cs_n_o(cs_n), .wr_n_o(wsn),
		.rd_n_o(rsn), .addr_o(ha), .data_o(hd), .data_i(dq), .data_oe_i(oe));
	uhb_host_port dut (.ref_clk_i(clk), .nrst_i(nrst), .bus_sel_i(bsel), .cs_n_i(cs_n),
		.write_strobe_n_i(wsn), .read_strobe_n_i(rsn), .addr_i(ha), .data_i(hd), .data_o(dq),
		.data_oe_o(oe), .reset_pin_i(rpin), .power_isolate_in_i(iso), .int_o(int_o),
		.int_oe_o(int_oe), .tx_o(tx), .rx_i(rx), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
		.cts_n_i(mdm_n[0]), .dsr_n_i(mdm_n[1]), .cd_n_i(mdm_n[2]), .ri_n_i(mdm_n[3]),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq_o(irq));

	task ck(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task axw(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (awrdy) awvalid <= 1'b0;
			if (wrdy) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		ck(bresp, er);
	endtask

	task axr(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge clk);
			if (arrdy) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		ck(rdata, {24'h0, e});
		ck(rresp, er);
	endtask

	// Counts high cycles per 16-cycle bit; infrared zero bit is a 3-cycle pulse
	task frame(input logic [7:0] d, input logic ir);
		logic [9:0] f;
		int n, c;
		f = {1'b1, d, 1'b0};
		n = 0;
		while (tx === !ir && n < 400) begin
			@(posedge clk);
			n++;
		end
		for (int b = 0; b < 10; b++) begin
			c = 0;
			repeat (16) begin
				c += (tx === 1'b1);
				@(posedge clk);
			end
			ck(c, ir ? (f[b] ? 0 : 3) : (f[b] ? 16 : 0));
		end
		ck(tx, !ir);
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		ck(tx, 1'b1);
		axr(`UHB_OFS_MODEM_CTRL, `UHB_MCR_RST, 2'h0);
		axr(`UHB_OFS_EXT_FEAT, `UHB_EFR_RST, 2'h0);
		axr(`UHB_OFS_INT_MASK, {4'h0, `UHB_MASK_RST}, 2'h0);
		axr(6'h18, 8'h00, 2'h2);
		axw(6'h18, 8'h01, 2'h2);
		axw(`UHB_OFS_INT_STAT, 8'h0F, 2'h0);
		host.acc(1'b1, 3'h1, 8'hA5, q);
		axr(`UHB_OFS_HOST_LAST, 8'hA5, 2'h0);
		host.acc(1'b0, `UHB_MSR_ADDR, 8'h00, q);
		ck(q, 8'h55);
		axr(`UHB_OFS_INT_STAT, 8'h03, 2'h0);
		axw(`UHB_OFS_MODEM_CTRL, 8'h08, 2'h0);
		axw(`UHB_OFS_INT_MASK, 8'h02, 2'h0);
		repeat (3) @(posedge clk);
		ck({irq, int_o, int_oe}, 3'h7);
		axw(`UHB_OFS_MODEM_CTRL, 8'h00, 2'h0);
		repeat (3) @(posedge clk);
		ck({irq, int_o, int_oe}, 3'h6);
		axw(`UHB_OFS_INT_STAT, 8'h02, 2'h0);
		repeat (3) @(posedge clk);
		ck({irq, int_o}, 2'h0);
		axw(`UHB_OFS_MODEM_CTRL, 8'h03, 2'h0);
		axw(`UHB_OFS_EXT_FEAT, 8'h40, 2'h0);
		ck({rts_n, dtr_n}, 2'h0);
		rpin <= 1'b1;
		repeat (5) @(posedge clk);
		rpin <= 1'b0;
		repeat (5) @(posedge clk);
		axr(`UHB_OFS_MODEM_CTRL, `UHB_MCR_RST, 2'h0);
		axr(`UHB_OFS_EXT_FEAT, `UHB_EFR_RST, 2'h0);
		ck({rts_n, dtr_n, tx}, 3'h7);
		axr(`UHB_OFS_INT_MASK, {4'h0, `UHB_MASK_RST}, 2'h0);
		fork
			host.acc(1'b1, `UHB_TX_ADDR, 8'h4B, q);
			frame(8'h4B, 1'b0);
		join
		axw(`UHB_OFS_MODEM_CTRL, 8'h40, 2'h0);
		rx <= 1'b0;
		repeat (3) @(posedge clk);
		ck(tx, 1'b0);
		fork
			host.acc(1'b1, `UHB_TX_ADDR, 8'hC2, q);
			frame(8'hC2, 1'b1);
		join
		axw(`UHB_OFS_MODEM_CTRL, 8'h00, 2'h0);
		rx <= 1'b1;
		axw(`UHB_OFS_EXT_FEAT, 8'h80, 2'h0);
		mdm_n <= 4'h9;
		fork
			host.acc(1'b1, `UHB_TX_ADDR, 8'h96, q);
			repeat (300) begin
				@(posedge clk);
				h += (tx === 1'b1);
			end
		join
		ck(h, 300);
		mdm_n <= 4'h8;
		frame(8'h96, 1'b0);
		axw(`UHB_OFS_EXT_FEAT, 8'h00, 2'h0);
		bsel <= 1'b0;
		rpin <= 1'b1;
		repeat (5) @(posedge clk);
		axw(`UHB_OFS_INT_STAT, 8'h0F, 2'h0);
		axw(`UHB_OFS_INT_MASK, 8'h01, 2'h0);
		host.acc(1'b1, 3'h1, 8'h3C, q);
		axr(`UHB_OFS_HOST_LAST, 8'h3C, 2'h0);
		ck({irq, int_o, int_oe}, 3'h5);
		host.acc(1'b0, `UHB_MSR_ADDR, 8'h00, q);
		ck(q, 8'hB4);
		iso <= 1'b1;
		repeat (5) @(posedge clk);
		host.acc(1'b1, 3'h1, 8'h77, q);
		axr(`UHB_OFS_HOST_LAST, 8'h3C, 2'h0);
		axr(`UHB_OFS_MODEM_STAT, 8'hB6, 2'h0);
		iso <= 1'b0;
		axw(`UHB_OFS_INT_STAT, 8'h0F, 2'h0);
		repeat (3) @(posedge clk);
		ck({irq, int_oe}, 2'h0);
		rpin <= 1'b0;
		repeat (5) @(posedge clk);
		rpin <= 1'b1;
		repeat (5) @(posedge clk);
		axr(`UHB_OFS_HOST_LAST, 8'h00, 2'h0);
		report_and_stop;
	end

	// Whole run is about 1100 cycles
	initial begin
		#(20000 * 100);
		failures++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		report_and_stop;
	end
endmodule
